// file: rtl/stretch_consts.svh
`ifndef STRETCH_CONSTS_SVH
`define STRETCH_CONSTS_SVH
`define CLOCK_CONTROL_ADDR     8'h8E
`define CLOCK_CONTROL_RESET    8'h01
`define STRETCH_MSB            2
`define STRETCH_LSB            0
`define CLOCKS_PER_MCYCLE      3'h4
`define MOVE_BASE_CYCLES       4'h2
`define ZERO_STRETCH_STROBE    5'h02
`endif

// file: rtl/stretch_pkg.sv
package stretch_pkg;
  // Phases of the external bus sequencer.
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_FETCH = 2'b01,
    BUS_DATA  = 2'b10
  } bus_state_type;
endpackage

// file: rtl/mcycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "stretch_consts.svh"
// Divides the oscillator clock into machine cycles of four clocks.
module mcycle_timer (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Phase within the machine cycle and a last-phase pulse.
  output logic [1:0] phase,
  output logic       cycle_end
);
  logic [1:0] phase_reg;   // Current clock within the cycle.
  logic [1:0] phase_next;  // Next phase.

  // Wrap after four clocks.
  always_comb begin
    phase_next = phase_reg + 2'h1;
  end

  // Register the phase.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase     = phase_reg;
  assign cycle_end = (phase_reg == 2'(`CLOCKS_PER_MCYCLE - 3'h1));
endmodule
`default_nettype wire

// file: rtl/stretch_bus.sv
`timescale 1ns/1ps
`default_nettype none
`include "stretch_consts.svh"
// Contract
// - Machine cycle is exactly four clocks.
// - Every instruction fetch goes to external bus.
// - Low address muxed on port, high separate.
// - Stretch affects data moves, not fetches.
// - Stretch is clock_control bits 2..0 at 8Eh.
// - Data move lasts stretch plus two cycles.
// - Stretch resets to one.
// - Strobe 2 clocks at zero, else 4*stretch.
// - Nonzero stretch widens strobe and timing proportionally.
// - One address latch pulse every machine cycle.
module stretch_bus
  import stretch_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Special-function register access from the core.
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  output logic [7:0]  sfr_rdata,
  // Core bus requests, taken at the end of a machine cycle.
  input  wire logic        fetch_req,
  input  wire logic        move_req,
  input  wire logic        move_write,
  input  wire logic [15:0] move_addr,
  input  wire logic [7:0]  move_wdata,
  input  wire logic [15:0] fetch_addr,
  output logic        busy,
  output logic        done,
  output logic [7:0]  rdata,
  // External pins.
  input  wire logic [7:0]  muxed_addr_data_port_in,
  output logic [7:0]  muxed_addr_data_port_out,
  output logic        muxed_addr_data_port_oe,
  output logic [7:0]  high_address_port,
  output logic        ale,
  output logic        rd_n,
  output logic        wr_n,
  output logic        psen_n
);
  logic [1:0]    phase;           // Clock within the machine cycle.
  logic          cycle_end;       // Last clock of the machine cycle.
  bus_state_type state_reg, state_next;
  logic [2:0]    stretch_reg, stretch_next;   // Software stretch field.
  logic [7:0]    ctl_upper_reg, ctl_upper_next; // Other clock_control bits, stored only.
  logic [2:0]    latched_reg, latched_next;   // Stretch frozen for the current move.
  logic [3:0]    mc_reg, mc_next;             // Machine cycles left in the move.
  logic [5:0]    clk_reg, clk_next;           // Clocks into the move; up to 36 at the longest stretch.
  logic          write_reg, write_next;
  logic [15:0]   addr_reg, addr_next;
  logic [7:0]    wdata_reg, wdata_next;
  logic [7:0]    rdata_reg, rdata_next;
  logic          done_reg, done_next;
  logic [7:0]    port_out_reg, port_out_next;
  logic          port_oe_reg, port_oe_next;
  logic          rd_n_reg, rd_n_next;
  logic          wr_n_reg, wr_n_next;
  logic          psen_n_reg, psen_n_next;
  logic [4:0]    strobe_len;      // Strobe width in clocks.
  logic [4:0]    strobe_start;    // First strobe clock of the move.
  logic [5:0]    strobe_end;      // First clock after the strobe.

  // Machine cycle divider; the address latch pulse rides on it.
  mcycle_timer u_timer (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  // Latch enable is high in the first clock of every machine cycle.
  assign ale = (phase == 2'h0);

  // Strobe width: two clocks at stretch zero, else four per stretch step.
  assign strobe_len   = (latched_reg == 3'h0) ? `ZERO_STRETCH_STROBE
                                              : {latched_reg, 2'b00};
  // The strobe starts after the address cycle: one clock into the second machine cycle at stretch zero, two clocks in otherwise.
  assign strobe_start = (latched_reg == 3'h0) ? 5'h05 : 5'h06;
  // Six bits hold the end of the longest strobe, which five bits would wrap to 2.
  assign strobe_end   = {1'b0, strobe_start} + {1'b0, strobe_len};

  // Register file and bus sequencer next-state logic.
  always_comb begin
    stretch_next  = stretch_reg;
    ctl_upper_next = ctl_upper_reg;
    state_next    = state_reg;
    latched_next  = latched_reg;
    mc_next       = mc_reg;
    clk_next      = clk_reg;
    write_next    = write_reg;
    addr_next     = addr_reg;
    wdata_next    = wdata_reg;
    rdata_next    = rdata_reg;
    done_next     = 1'b0;
    port_out_next = port_out_reg;
    port_oe_next  = port_oe_reg;
    rd_n_next     = 1'b1;
    wr_n_next     = 1'b1;
    psen_n_next   = 1'b1;
    // Software may rewrite the field at any time; moves in flight keep their copy.
    if (sfr_wr && (sfr_addr == `CLOCK_CONTROL_ADDR)) begin
      stretch_next  = sfr_wdata[`STRETCH_MSB:`STRETCH_LSB];
      ctl_upper_next = {sfr_wdata[7:3], 3'h0};
    end
    case (state_reg)
      BUS_IDLE: begin
        port_oe_next = 1'b0;
        if (cycle_end && move_req) begin
          // Freeze the stretch now so later writes wait for the next move.
          state_next   = BUS_DATA;
          latched_next = stretch_reg;
          mc_next      = 4'(stretch_reg) + `MOVE_BASE_CYCLES;
          clk_next     = 6'h00;
          write_next   = move_write;
          addr_next    = move_addr;
          wdata_next   = move_wdata;
          port_out_next = move_addr[7:0];
          port_oe_next  = 1'b1;
        end else if (cycle_end && fetch_req) begin
          // Fetches always take one unstretched machine cycle.
          state_next    = BUS_FETCH;
          addr_next     = fetch_addr;
          port_out_next = fetch_addr[7:0];
          port_oe_next  = 1'b1;
        end
      end
      BUS_FETCH: begin
        // Address for one clock, then program strobe while the port floats.
        port_oe_next = 1'b0;
        psen_n_next  = (phase == 2'h3);
        if (phase == 2'h2) begin
          rdata_next = muxed_addr_data_port_in;
        end
        if (cycle_end) begin
          state_next = BUS_IDLE;
          done_next  = 1'b1;
        end
      end
      BUS_DATA: begin
        clk_next = clk_reg + 6'h01;
        // Strobe covers its window of the move, proportional to the stretch.
        if ((clk_reg + 6'h01 >= {1'b0, strobe_start}) && (clk_reg + 6'h01 < strobe_end)) begin
          rd_n_next    = write_reg;
          wr_n_next    = ~write_reg;
          port_oe_next = write_reg;
          port_out_next = wdata_reg;
        end else begin
          port_oe_next = 1'b0;
        end
        // Sample read data on the last strobe clock.
        if (!write_reg && (clk_reg + 6'h01 == strobe_end)) begin
          rdata_next = muxed_addr_data_port_in;
        end
        if (cycle_end) begin
          mc_next = mc_reg - 4'h1;
          if (mc_reg == 4'h1) begin
            state_next   = BUS_IDLE;
            done_next    = 1'b1;
            port_oe_next = 1'b0;
          end
        end
      end
      default: begin
        state_next = BUS_IDLE;
      end
    endcase
  end

  // Register every piece of state.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg    <= BUS_IDLE;
      stretch_reg  <= 3'(`CLOCK_CONTROL_RESET);
      ctl_upper_reg <= 8'h00;
      latched_reg  <= 3'h0;
      mc_reg       <= 4'h0;
      clk_reg      <= 6'h00;
      write_reg    <= 1'b0;
      addr_reg     <= 16'h0000;
      wdata_reg    <= 8'h00;
      rdata_reg    <= 8'h00;
      done_reg     <= 1'b0;
      port_out_reg <= 8'h00;
      port_oe_reg  <= 1'b0;
      rd_n_reg     <= 1'b1;
      wr_n_reg     <= 1'b1;
      psen_n_reg   <= 1'b1;
    end else begin
      state_reg    <= state_next;
      stretch_reg  <= stretch_next;
      ctl_upper_reg <= ctl_upper_next;
      latched_reg  <= latched_next;
      mc_reg       <= mc_next;
      clk_reg      <= clk_next;
      write_reg    <= write_next;
      addr_reg     <= addr_next;
      wdata_reg    <= wdata_next;
      rdata_reg    <= rdata_next;
      done_reg     <= done_next;
      port_out_reg <= port_out_next;
      port_oe_reg  <= port_oe_next;
      rd_n_reg     <= rd_n_next;
      wr_n_reg     <= wr_n_next;
      psen_n_reg   <= psen_n_next;
    end
  end

  // Reads of the register return the stored field; other addresses read zero.
  assign sfr_rdata = (sfr_addr == `CLOCK_CONTROL_ADDR) ? (ctl_upper_reg | {5'h00, stretch_reg}) : 8'h00;
  assign busy      = (state_reg != BUS_IDLE);
  assign done      = done_reg;
  assign rdata     = rdata_reg;
  assign muxed_addr_data_port_out = port_out_reg;
  assign muxed_addr_data_port_oe  = port_oe_reg;
  assign high_address_port = addr_reg[15:8];
  assign rd_n      = rd_n_reg;
  assign wr_n      = wr_n_reg;
  assign psen_n    = psen_n_reg;
endmodule
`default_nettype wire

// file: tb/ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// External memory: latches the low address once per transfer and answers reads from it.
module ext_mem_model (
  // Clock.
  input  wire logic        clk,
  // Latch pulse and strobes from the block.
  input  wire logic        ale,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        psen_n,
  // Address and data lines.
  input  wire logic [7:0]  muxed_addr_data_port_out,
  input  wire logic        muxed_addr_data_port_oe,
  input  wire logic [7:0]  high_address_port,
  output logic      [7:0]  muxed_addr_data_port_in,
  // Last write seen: high address, low address, data.
  output logic      [23:0] last_wr
);
  logic [23:0] wr_seen = 24'h000000; // Last write, held for the bench.
  logic [7:0] lo = 8'h00;
  logic [7:0] dv = 8'h00;
  logic       arm = 1'b1;
  logic       idle_q = 1'b1;
  wire logic  idle = rd_n && wr_n && psen_n;
  // Off a read the lines toggle each cycle, so stale data never passes.
  assign muxed_addr_data_port_in = (!rd_n || !psen_n) ? (lo ^ high_address_port ^ 8'hA5) : ~dv;
  assign last_wr = wr_seen;
  // Only the first latch pulse of a transfer carries the address; later ones may carry data.
  always @(posedge clk) begin
    dv <= muxed_addr_data_port_in;
    idle_q <= idle;
    if (ale && muxed_addr_data_port_oe && arm) begin
      lo <= muxed_addr_data_port_out;
      arm <= 1'b0;
    end else if (idle && !idle_q) begin
      arm <= 1'b1;
    end
    if (!wr_n) wr_seen <= {high_address_port, lo, muxed_addr_data_port_out};
  end
endmodule
`default_nettype wire

// file: tb/stretch_chk.sv
`timescale 1ns/1ps
`default_nettype none
module stretch_chk (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register access and requests from the core.
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic        move_req,
  input wire logic        move_write,
  input wire logic [15:0] move_addr,
  input wire logic [7:0]  move_wdata,
  // Answers to the core.
  input wire logic        busy,
  input wire logic        done,
  input wire logic [7:0]  rdata,
  // External pins.
  input wire logic [7:0]  muxed_addr_data_port_in,
  input wire logic [7:0]  muxed_addr_data_port_out,
  input wire logic        muxed_addr_data_port_oe,
  input wire logic [7:0]  high_address_port,
  input wire logic        ale,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        psen_n
);
  logic [7:0] ctl_reg, ctl_next; // Shadow of clock_control.
  logic [2:0] st_reg, st_next;   // Stretch frozen while a transfer runs.
  logic [5:0] sw_reg, sw_next;   // Strobe width so far.
  logic [5:0] bc_reg, bc_next;   // Busy length so far.
  logic       mv_reg, mv_next;   // A data strobe was seen in this transfer.
  // Next values of the helper state.
  always_comb begin
    ctl_next = sys_rst ? 8'h01 : (sfr_wr && sfr_addr == 8'h8E) ? sfr_wdata : ctl_reg;
    st_next = busy ? st_reg : ctl_reg[2:0];
    sw_next = (rd_n && wr_n) ? 6'h00 : sw_reg + 6'h01;
    bc_next = busy ? bc_reg + 6'h01 : 6'h00;
    mv_next = busy && (mv_reg || !rd_n || !wr_n);
  end
  // Registers only.
  always_ff @(posedge clk) begin
    ctl_reg <= ctl_next;
    st_reg <= st_next;
    sw_reg <= sw_next;
    bc_reg <= bc_next;
    mv_reg <= mv_next;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence ale_gap;
    !ale [*3] ##1 ale;
  endsequence
  ale_period_a: assert property (ale |=> ale_gap) else $error("latch pulse spacing");
  // A fetch holds its program strobe for three clocks, whatever the stretch.
  sequence fetch_strobe;
    !psen_n [*3] ##1 psen_n;
  endsequence
  fetch_fixed_a: assert property ($fell(psen_n) |-> fetch_strobe) else $error("fetch strobe width");
  // The end pulse comes exactly in the first idle cycle of every transfer.
  done_pulse_a: assert property (done == $fell(busy)) else $error("done pulse");
  one_strobe_a: assert property (!psen_n |-> rd_n && wr_n) else $error("strobes overlap");
  strobe_width_a: assert property ($rose(rd_n && wr_n) |->
    sw_reg == ((st_reg == 3'h0) ? 6'h02 : {1'b0, st_reg, 2'b00})) else $error("strobe width");
  move_len_a: assert property ($fell(busy) && mv_reg |->
    bc_reg == (({3'h0, st_reg} + 6'h02) << 2)) else $error("move length");
  fetch_len_a: assert property ($fell(busy) && !mv_reg |-> bc_reg == 6'h04) else $error("fetch length");
  ctl_read_a: assert property (sfr_addr == 8'h8E |-> sfr_rdata == ctl_reg) else $error("control read");
  reset_idle_a: assert property (disable iff (1'b0) sys_rst |=> rd_n && wr_n && psen_n && !done)
    else $error("reset state");
  wr_data_a: assert property (!wr_n |-> muxed_addr_data_port_oe && muxed_addr_data_port_out == move_wdata)
    else $error("write data");
  rd_float_a: assert property (!rd_n |-> !muxed_addr_data_port_oe) else $error("port driven on read");
endmodule
bind stretch_bus stretch_chk chk (.*);
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  logic clk = 0, sys_rst = 1, sfr_wr = 0, fetch_req = 0, move_req = 0, move_write = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, move_wdata = 8'h00, sfr_rdata, rdata;
  logic [7:0] muxed_addr_data_port_in, muxed_addr_data_port_out, high_address_port;
  logic [15:0] move_addr = 16'h0000, fetch_addr = 16'h0000;
  logic busy, done, muxed_addr_data_port_oe, ale, rd_n, wr_n, psen_n;
  logic [23:0] last_wr;
  int mismatches = 0, n_compared = 0, cyc = 0, n;
  initial forever #5 clk = ~clk;
  stretch_bus dut (.*);
  ext_mem_model mem (.*);
  // Software may rewrite the stretch whenever it likes.
  task automatic set_ctl(input logic [7:0] v);
    @(negedge clk);
    sfr_addr = 8'h8E;
    sfr_wr = 1;
    sfr_wdata = v;
    @(negedge clk);
    sfr_wr = 0;
  endtask
  // One transfer; n counts busy cycles, chg rewrites the stretch mid-move.
  task automatic xfer(input logic f, w, input logic [15:0] a, input logic [7:0] d, input logic chg);
    @(negedge clk);
    {fetch_req, move_req, move_write, move_addr, fetch_addr, move_wdata} = {f, !f, w, a, a, d};
    for (int i = 0; i < 8 && busy !== 1'b1; i++) @(negedge clk);
    {fetch_req, move_req, n} = 0;
    if (chg) begin
      {sfr_addr, sfr_wr, sfr_wdata, n} = {8'h8E, 1'b1, 8'h07, 32'd1};
      @(negedge clk);
      sfr_wr = 0;
    end
    while (busy === 1'b1 && n < 60) begin
      n++;
      @(negedge clk);
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic t_reset;
    @(negedge clk);
    sfr_addr = 8'h8E;
    #1 `CHK(sfr_rdata, 8'h01)
    @(negedge clk);
    sfr_addr = 8'h8F;
    #1 `CHK(sfr_rdata, 8'h00)
    xfer(0, 0, 16'h5A3C, 8'h00, 0);
    `CHK(n, 12)
    $display("test reset done");
  endtask
  task automatic t_moves;
    for (int s = 0; s < 8; s++) begin
      set_ctl({5'h15, s[2:0]});
      `CHK(sfr_rdata, {5'h15, s[2:0]})
      xfer(0, 1, 16'h1234 + 16'h0101 * s, 8'hC0 + s, 0);
      `CHK(n, (s + 2) * 4)
      `CHK(last_wr, {16'h1234 + 16'h0101 * s, 8'hC0 + s[7:0]})
      xfer(0, 0, 16'h8001 + 16'h0110 * s, 8'h00, 0);
      `CHK(n, (s + 2) * 4)
      `CHK(rdata, (8'h01 + 8'h10 * s[7:0]) ^ (8'h80 + s[7:0]) ^ 8'hA5)
    end
    $display("test moves done");
  endtask
  task automatic t_fetch;
    xfer(1, 0, 16'hBEEF, 8'h00, 0);
    `CHK(n, 4)
    `CHK(rdata, 8'hEF ^ 8'hBE ^ 8'hA5)
    $display("test fetch done");
  endtask
  task automatic t_change;
    set_ctl(8'h00);
    xfer(0, 0, 16'h4321, 8'h00, 1);
    `CHK(n, 8)
    xfer(0, 0, 16'h4321, 8'h00, 0);
    `CHK(n, 36)
    $display("test change done");
  endtask
  task test_done;
    $display("compared %0d, wrong %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      test_done;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    sys_rst = 0;
    t_reset;
    t_moves;
    t_fetch;
    t_change;
    test_done;
  end
endmodule
`default_nettype wire
